// [hw/hcpi_defs.vh]
`ifndef HCPI_DEFS_VH
`define HCPI_DEFS_VH
// ==========================================
// object indices
`define HCPI_IDX_ACTUAL_TORQUE      16'h6077
`define HCPI_IDX_TARGET_POSITION    16'h607A
`define HCPI_IDX_HOME_ZERO_OFFSET   16'h607C
`define HCPI_IDX_HOMING_METHOD      16'h6098
`define HCPI_IDX_HOMING_SPEEDS      16'h6099
`define HCPI_IDX_HOMING_ACCEL       16'h609A
`define HCPI_IDX_VELOCITY_OFFSET    16'h60B1
`define HCPI_IDX_INTERP_PERIOD      16'h60C2
// ==========================================
// sub-indices
`define HCPI_SUB_COUNT              8'h00
`define HCPI_SUB_ONE                8'h01
`define HCPI_SUB_TWO                8'h02
`define HCPI_SPEEDS_LAST_SUB        32'h00000002
// ==========================================
// reset values and limits
`define HCPI_RST_WORD               32'h00000000
`define HCPI_RST_METHOD             8'h00
`define HCPI_RST_UNITS              8'h04
`define HCPI_RST_EXP                8'hFD
`define HCPI_METHOD_MAX             8'h23
`define HCPI_EXP_MIN                -6
`define HCPI_TORQUE_MAX             32'sh00007FFF
`define HCPI_TORQUE_MIN             -32'sh00008000
// ==========================================
// timing: control-loop cycle 250 us at 250 MHz
`define HCPI_CLK_MHZ                250
`define HCPI_LOOP_US                250
`define HCPI_LOOP_CYCLES            (`HCPI_LOOP_US * `HCPI_CLK_MHZ)
`endif

// [hw/hcpi_loop_tick.v]
`timescale 1ns/1ns
`include "hcpi_defs.vh"
// ==========================================
// control-loop tick divider; when enabled the tick is the sync pulse and the divider is held at zero
module hcpi_loop_tick #(
    parameter LOOP_CYCLES = `HCPI_LOOP_CYCLES
) (
    // clock and reset
    input  wire i_clk,
    input  wire i_reset,
    // sync
    input  wire i_dc_enable,
    input  wire i_sync_pulse,
    // tick
    output reg  o_tick
);
    reg [31:0] cnt_q;
    wire       wrap = (cnt_q == LOOP_CYCLES - 1);

    always @(posedge i_clk) begin
        if (i_reset) begin
            cnt_q  <= 32'h00000000;
            o_tick <= 1'b0;
        end else if (i_dc_enable) begin
            // position loop follows the distributed-clock sync
            o_tick <= i_sync_pulse;
            cnt_q  <= 32'h00000000;
        end else begin
            o_tick <= wrap;
            cnt_q  <= wrap ? 32'h00000000 : cnt_q + 32'h00000001;
        end
    end
endmodule

// [hw/hcpi_interp.v]
`timescale 1ns/1ns
`include "hcpi_defs.vh"
// ==========================================
// linear interpolator: two stored points, even steps per loop tick
module hcpi_interp (
    // clock and reset
    input  wire        i_clk,
    input  wire        i_reset,
    // control
    input  wire        i_run,
    input  wire        i_tick,
    input  wire        i_load,
    input  wire [15:0] i_steps,
    input  wire [31:0] i_target,
    // outputs
    output reg  [31:0] o_cmd,
    output reg  [31:0] o_vel
);
    reg  [31:0] prev_q;
    reg  [31:0] newest_q;
    reg  [15:0] step_q;
    reg  [31:0] delta_q;
    wire [31:0] diff = i_target - newest_q;
    wire [47:0] prod = $signed(delta_q) * $signed({16'h0000, step_q});
    wire [31:0] quot = (i_steps == 16'h0000) ? $signed(diff) :
                       $signed(diff) / $signed({16'h0000, i_steps});

    always @(posedge i_clk) begin
        if (i_reset) begin
            prev_q   <= 32'h00000000;
            newest_q <= 32'h00000000;
            step_q   <= 16'h0000;
            delta_q  <= 32'h00000000;
            o_cmd    <= 32'h00000000;
            o_vel    <= 32'h00000000;
        end else if (!i_run) begin
            prev_q   <= i_target;
            newest_q <= i_target;
            step_q   <= 16'h0000;
            delta_q  <= 32'h00000000;
            o_cmd    <= i_target;
            o_vel    <= 32'h00000000;
        end else if (i_load) begin
            // oldest point dropped; output lags one command
            prev_q   <= newest_q;
            newest_q <= i_target;
            step_q   <= 16'h0000;
            delta_q  <= quot;
            o_vel    <= quot;
        end else if (i_tick) begin
            if (step_q < i_steps)
                step_q <= step_q + 16'h0001;
            o_cmd <= prev_q + prod[31:0];
        end
    end
endmodule

// [hw/hcpi_top.v]
`timescale 1ns/1ns
`include "hcpi_defs.vh"
// Functional notes
// - on homing done, zero position = found home plus home offset
// - absolute moves after homing are taken relative to new zero
// - home offset is signed; negative shifts the other way
// - homing method 0 means none, 1 to 35 select a method, default 0
// - homing speeds: last sub 2, sub1 switch search, sub2 zero search
// - one homing acceleration used for accel and decel
// - linear interpolation adds one position command of latency
// - interpolation period must be whole multiple of loop cycle; checked
// - period exponent below -6 is stored but raises the period fault
// - velocity feed-forward is computed for the position loop
// - target position sampled once per interpolation period
// - two points kept; oldest dropped on each new target
// - torque reported signed in 0.1 percent, clamped to 16 bits
// - velocity offset is the feed-forward input
// - cyclic position mode only in servo mode
// - without distributed clocks loop runs every 250 us
module hcpi_top #(
    parameter LOOP_CYCLES = `HCPI_LOOP_CYCLES
) (
    // clock and reset
    input  wire        I_MCLK,
    input  wire        I_RESET,
    // object access port
    input  wire        I_OBJ_WR,
    input  wire        I_OBJ_RD,
    input  wire [15:0] I_OBJ_INDEX,
    input  wire [7:0]  I_OBJ_SUB,
    input  wire [31:0] I_OBJ_WDATA,
    output reg  [31:0] O_OBJ_RDATA,
    output reg         O_OBJ_ACK,
    output reg         O_OBJ_ERR,
    // drive state
    input  wire        I_SERVO_MODE,
    input  wire        I_CSP_SELECT,
    input  wire        I_DC_ENABLE,
    input  wire        I_SYNC_PULSE,
    input  wire        I_HOMING_DONE,
    input  wire [31:0] I_HOME_FOUND_POS,
    input  wire [31:0] I_FEEDBACK_POS,
    input  wire [31:0] I_TORQUE_RAW,
    // outputs to motion core
    output reg         O_CSP_ACTIVE,
    output reg         O_PERIOD_FAULT,
    output reg  [31:0] O_POS_CMD,
    output reg  [31:0] O_VEL_FF,
    output reg  [31:0] O_ZERO_POS,
    output reg  [31:0] O_APP_POS,
    output reg  [7:0]  O_HOMING_METHOD,
    output reg  [31:0] O_SWITCH_SPEED,
    output reg  [31:0] O_ZERO_SPEED,
    output reg  [31:0] O_HOMING_ACCEL,
    output reg  [31:0] O_HOMING_DECEL
);
    // ==========================================
    // object storage
    reg  [31:0] target_q;
    reg  [31:0] offset_q;
    reg  [7:0]  method_q;

    reg  [31:0] sw_speed_q;
    reg  [31:0] zr_speed_q;
    reg  [31:0] accel_q;
    reg  [31:0] vel_off_q;

    reg  [7:0]  period_units_q;
    reg  [7:0]  period_exp_q;
    reg  [15:0] torque_q;

    reg  [15:0] tick_cnt_q;
    reg  [15:0] steps_q;
    reg         load_q;

    wire        tick;
    wire [31:0] cmd_w;
    wire [31:0] vel_w;

    wire        csp_run = I_CSP_SELECT & I_SERVO_MODE & ~O_PERIOD_FAULT;

    function hit;
        input [15:0] idx;
        input [7:0]  sub;
        input [15:0] want_idx;
        input [7:0]  want_sub;
        begin
            hit = (idx == want_idx) && (sub == want_sub);
        end
    endfunction

    // exponent in -6..0, then period in whole loop cycles of 250 us
    function [15:0] period_steps;
        input [7:0] units;
        input [7:0] expo;
        reg   [31:0] us;
        begin
            us = 32'h00000000;
            case (expo)
                8'hFA: us = {24'h000000, units};
                8'hFB: us = {24'h000000, units} * 32'h0000000A;
                8'hFC: us = {24'h000000, units} * 32'h00000064;
                8'hFD: us = {24'h000000, units} * 32'h000003E8;
                8'hFE: us = {24'h000000, units} * 32'h00002710;
                8'hFF: us = {24'h000000, units} * 32'h000186A0;
                8'h00: us = {24'h000000, units} * 32'h000F4240;
                default: us = 32'h00000000;
            endcase

            if ((us == 32'h00000000) || (us % `HCPI_LOOP_US != 0))
                us = 32'h00000000;
            else
                us = us / `HCPI_LOOP_US;
            // steps wrap above 16 bits
            period_steps = us[15:0];
        end
    endfunction

    wire [15:0] steps_w = period_steps(period_units_q, period_exp_q);

    // ==========================================
    // object writes and reads
    wire wr_ok = hit(I_OBJ_INDEX, I_OBJ_SUB, `HCPI_IDX_TARGET_POSITION, `HCPI_SUB_COUNT) |
                 hit(I_OBJ_INDEX, I_OBJ_SUB, `HCPI_IDX_HOME_ZERO_OFFSET, `HCPI_SUB_COUNT) |
                 (hit(I_OBJ_INDEX, I_OBJ_SUB, `HCPI_IDX_HOMING_METHOD, `HCPI_SUB_COUNT) &&
                  (I_OBJ_WDATA[7:0] <= `HCPI_METHOD_MAX) && (I_OBJ_WDATA[31:8] == 24'h0)) |
                 hit(I_OBJ_INDEX, I_OBJ_SUB, `HCPI_IDX_HOMING_SPEEDS, `HCPI_SUB_ONE) |
                 hit(I_OBJ_INDEX, I_OBJ_SUB, `HCPI_IDX_HOMING_SPEEDS, `HCPI_SUB_TWO) |
                 hit(I_OBJ_INDEX, I_OBJ_SUB, `HCPI_IDX_HOMING_ACCEL, `HCPI_SUB_COUNT) |
                 hit(I_OBJ_INDEX, I_OBJ_SUB, `HCPI_IDX_VELOCITY_OFFSET, `HCPI_SUB_COUNT) |
                 hit(I_OBJ_INDEX, I_OBJ_SUB, `HCPI_IDX_INTERP_PERIOD, `HCPI_SUB_ONE) |
                 hit(I_OBJ_INDEX, I_OBJ_SUB, `HCPI_IDX_INTERP_PERIOD, `HCPI_SUB_TWO);

    reg [31:0] rd_d;
    reg        rd_ok;
    always @* begin
        rd_ok = 1'b1;
        rd_d  = 32'h00000000;

        if (hit(I_OBJ_INDEX, I_OBJ_SUB, `HCPI_IDX_ACTUAL_TORQUE, `HCPI_SUB_COUNT))
            rd_d = {{16{torque_q[15]}}, torque_q};
        else if (hit(I_OBJ_INDEX, I_OBJ_SUB, `HCPI_IDX_TARGET_POSITION, `HCPI_SUB_COUNT))
            rd_d = target_q;
        else if (hit(I_OBJ_INDEX, I_OBJ_SUB, `HCPI_IDX_HOME_ZERO_OFFSET, `HCPI_SUB_COUNT))
            rd_d = offset_q;
        else if (hit(I_OBJ_INDEX, I_OBJ_SUB, `HCPI_IDX_HOMING_METHOD, `HCPI_SUB_COUNT))
            rd_d = {24'h000000, method_q};
        else if (hit(I_OBJ_INDEX, I_OBJ_SUB, `HCPI_IDX_HOMING_SPEEDS, `HCPI_SUB_COUNT))
            rd_d = `HCPI_SPEEDS_LAST_SUB;
        else if (hit(I_OBJ_INDEX, I_OBJ_SUB, `HCPI_IDX_HOMING_SPEEDS, `HCPI_SUB_ONE))
            rd_d = sw_speed_q;
        else if (hit(I_OBJ_INDEX, I_OBJ_SUB, `HCPI_IDX_HOMING_SPEEDS, `HCPI_SUB_TWO))
            rd_d = zr_speed_q;
        else if (hit(I_OBJ_INDEX, I_OBJ_SUB, `HCPI_IDX_HOMING_ACCEL, `HCPI_SUB_COUNT))
            rd_d = accel_q;
        else if (hit(I_OBJ_INDEX, I_OBJ_SUB, `HCPI_IDX_VELOCITY_OFFSET, `HCPI_SUB_COUNT))
            rd_d = vel_off_q;
        else if (hit(I_OBJ_INDEX, I_OBJ_SUB, `HCPI_IDX_INTERP_PERIOD, `HCPI_SUB_ONE))
            rd_d = {24'h000000, period_units_q};
        else if (hit(I_OBJ_INDEX, I_OBJ_SUB, `HCPI_IDX_INTERP_PERIOD, `HCPI_SUB_TWO))
            rd_d = {{24{period_exp_q[7]}}, period_exp_q};
        else
            rd_ok = 1'b0;
    end

    // ==========================================
    // torque clamp to 16-bit signed
    wire signed [31:0] trq = I_TORQUE_RAW;
    wire [15:0] trq_sat = (trq > `HCPI_TORQUE_MAX) ? 16'h7FFF :
                          (trq < `HCPI_TORQUE_MIN) ? 16'h8000 : trq[15:0];

    always @(posedge I_MCLK) begin
        if (I_RESET) begin
            target_q       <= `HCPI_RST_WORD;
            offset_q       <= `HCPI_RST_WORD;
            method_q       <= `HCPI_RST_METHOD;
            sw_speed_q     <= `HCPI_RST_WORD;
            zr_speed_q     <= `HCPI_RST_WORD;
            accel_q        <= `HCPI_RST_WORD;
            vel_off_q      <= `HCPI_RST_WORD;
            period_units_q <= `HCPI_RST_UNITS;
            period_exp_q   <= `HCPI_RST_EXP;
            torque_q       <= 16'h0000;
            O_OBJ_RDATA    <= 32'h00000000;
            O_OBJ_ACK      <= 1'b0;
            O_OBJ_ERR      <= 1'b0;
        end else begin
            torque_q  <= trq_sat;

            O_OBJ_ACK <= I_OBJ_WR | I_OBJ_RD;
            O_OBJ_ERR <= (I_OBJ_WR & ~wr_ok) | (I_OBJ_RD & ~rd_ok);

            if (I_OBJ_RD)
                O_OBJ_RDATA <= rd_ok ? rd_d : 32'h00000000;

            if (I_OBJ_WR && wr_ok) begin
                case (I_OBJ_INDEX)
                    `HCPI_IDX_TARGET_POSITION:  target_q <= I_OBJ_WDATA;
                    `HCPI_IDX_HOME_ZERO_OFFSET: offset_q <= I_OBJ_WDATA;
                    `HCPI_IDX_HOMING_METHOD:    method_q <= I_OBJ_WDATA[7:0];
                    `HCPI_IDX_HOMING_SPEEDS: begin
                        if (I_OBJ_SUB == `HCPI_SUB_ONE)
                            sw_speed_q <= I_OBJ_WDATA;
                        else
                            zr_speed_q <= I_OBJ_WDATA;
                    end
                    `HCPI_IDX_HOMING_ACCEL:     accel_q <= I_OBJ_WDATA;
                    `HCPI_IDX_VELOCITY_OFFSET:  vel_off_q <= I_OBJ_WDATA;
                    `HCPI_IDX_INTERP_PERIOD: begin
                        if (I_OBJ_SUB == `HCPI_SUB_ONE)
                            period_units_q <= I_OBJ_WDATA[7:0];
                        else
                            period_exp_q <= I_OBJ_WDATA[7:0];
                    end
                    default: ;
                endcase
            end
        end
    end

    // ==========================================
    // loop tick and interpolation period
    hcpi_loop_tick #(
        .LOOP_CYCLES (LOOP_CYCLES)
    ) u_tick (
        .i_clk        (I_MCLK),
        .i_reset      (I_RESET),
        .i_dc_enable  (I_DC_ENABLE),
        .i_sync_pulse (I_SYNC_PULSE),
        .o_tick       (tick)
    );

    // one load per period, on the tick that opens it
    always @(posedge I_MCLK) begin
        if (I_RESET) begin
            tick_cnt_q <= 16'h0000;
            steps_q    <= 16'h0001;
            load_q     <= 1'b0;
        end else begin
            load_q <= 1'b0;

            if (!csp_run) begin
                tick_cnt_q <= 16'h0000;
            end else if (tick) begin
                if (tick_cnt_q == 16'h0000) begin
                    load_q  <= 1'b1;
                    steps_q <= steps_w;
                end
                tick_cnt_q <= (tick_cnt_q + 16'h0001 >= steps_w) ? 16'h0000 :
                              tick_cnt_q + 16'h0001;
            end
        end
    end

    hcpi_interp u_interp (
        .i_clk    (I_MCLK),
        .i_reset  (I_RESET),
        .i_run    (csp_run),
        .i_tick   (tick),
        .i_load   (load_q),
        .i_steps  (steps_q),
        .i_target (target_q),
        .o_cmd    (cmd_w),
        .o_vel    (vel_w)
    );

    // ==========================================
    // outputs; homing zero latched on completion
    always @(posedge I_MCLK) begin
        if (I_RESET) begin
            O_CSP_ACTIVE    <= 1'b0;
            O_PERIOD_FAULT  <= 1'b0;
            O_POS_CMD       <= 32'h00000000;
            O_VEL_FF        <= 32'h00000000;
            O_ZERO_POS      <= 32'h00000000;
            O_APP_POS       <= 32'h00000000;
            O_HOMING_METHOD <= `HCPI_RST_METHOD;
            O_SWITCH_SPEED  <= 32'h00000000;
            O_ZERO_SPEED    <= 32'h00000000;
            O_HOMING_ACCEL  <= 32'h00000000;
            O_HOMING_DECEL  <= 32'h00000000;
        end else begin
            O_PERIOD_FAULT  <= (steps_w == 16'h0000);
            O_CSP_ACTIVE    <= csp_run;

            // absolute command shifted by the homed zero
            O_POS_CMD       <= cmd_w + O_ZERO_POS;
            O_VEL_FF        <= vel_w + vel_off_q;
            if (I_HOMING_DONE)
                O_ZERO_POS  <= I_HOME_FOUND_POS + offset_q;
            O_APP_POS       <= I_FEEDBACK_POS - O_ZERO_POS;

            O_HOMING_METHOD <= method_q;
            O_SWITCH_SPEED  <= sw_speed_q;
            O_ZERO_SPEED    <= zr_speed_q;
            O_HOMING_ACCEL  <= accel_q;
            O_HOMING_DECEL  <= accel_q;
        end
    end
endmodule

// [testbench/hcpi_checker.sv]
`timescale 1ns/1ns
`include "hcpi_defs.vh"
// ==========================================
// port checker
module hcpi_checker (
    // clock and reset
    input wire        I_MCLK,
    input wire        I_RESET,
    // object port
    input wire        I_OBJ_WR,
    input wire        I_OBJ_RD,
    input wire [15:0] I_OBJ_INDEX,
    input wire [7:0]  I_OBJ_SUB,
    input wire [31:0] I_OBJ_WDATA,
    input wire [31:0] O_OBJ_RDATA,
    input wire        O_OBJ_ACK,
    input wire        O_OBJ_ERR,
    // drive state and outputs
    input wire        I_SERVO_MODE,
    input wire        I_HOMING_DONE,
    input wire [31:0] I_HOME_FOUND_POS,
    input wire [31:0] I_FEEDBACK_POS,
    input wire        O_CSP_ACTIVE,
    input wire        O_PERIOD_FAULT,
    input wire [31:0] O_ZERO_POS,
    input wire [31:0] O_APP_POS,
    input wire [7:0]  O_HOMING_METHOD,
    input wire [31:0] O_HOMING_ACCEL,
    input wire [31:0] O_HOMING_DECEL
);
    default clocking @(posedge I_MCLK); endclocking
    default disable iff (I_RESET);
    // ==========================================
    // shadow of the home offset, taken only from acknowledged good writes
    reg        wr_q;
    reg [15:0] ix_q;
    reg [31:0] wd_q;
    reg [31:0] off_q;
    always @(posedge I_MCLK) begin
        wr_q <= I_OBJ_WR;
        ix_q <= I_OBJ_INDEX;
        wd_q <= I_OBJ_WDATA;
        if (I_RESET)
            off_q <= 32'h00000000;
        else if (O_OBJ_ACK && !O_OBJ_ERR && wr_q && ix_q == `HCPI_IDX_HOME_ZERO_OFFSET)
            off_q <= wd_q;
    end
    // ==========================================
    // assertions
    a_zero_from_home: assert property (I_HOMING_DONE |=>
        O_ZERO_POS == $past(I_HOME_FOUND_POS) + off_q) else $error("zero position wrong");
    a_app_relative: assert property ($stable(I_FEEDBACK_POS) && $stable(O_ZERO_POS) |=>
        O_APP_POS == $past(I_FEEDBACK_POS) - $past(O_ZERO_POS)) else $error("app pos wrong");
    a_method_limit: assert property (O_HOMING_METHOD <= 8'h23)
        else $error("homing method above range");
    a_method_refuse: assert property (I_OBJ_WR && I_OBJ_INDEX == `HCPI_IDX_HOMING_METHOD &&
        I_OBJ_WDATA > 32'h00000023 |=> O_OBJ_ACK && O_OBJ_ERR) else $error("method not refused");
    a_speed_count: assert property (I_OBJ_RD && I_OBJ_INDEX == `HCPI_IDX_HOMING_SPEEDS &&
        I_OBJ_SUB == 8'h00 |=> O_OBJ_RDATA == 32'h00000002 && !O_OBJ_ERR) else $error("count");
    a_one_accel: assert property (O_HOMING_DECEL == O_HOMING_ACCEL)
        else $error("decel differs from accel");
    a_period_halt: assert property (O_PERIOD_FAULT [*2] |-> !O_CSP_ACTIVE)
        else $error("cyclic mode runs with bad period");
    a_exp_floor: assert property (I_OBJ_WR && I_OBJ_INDEX == `HCPI_IDX_INTERP_PERIOD &&
        I_OBJ_SUB == 8'h02 && $signed(I_OBJ_WDATA[7:0]) < -6 |=> ##[0:4] O_PERIOD_FAULT)
        else $error("exponent below floor accepted");
    a_torque_ro: assert property (I_OBJ_WR && I_OBJ_INDEX == `HCPI_IDX_ACTUAL_TORQUE |=>
        O_OBJ_ERR) else $error("torque write not refused");
    a_torque_span: assert property (I_OBJ_RD && I_OBJ_INDEX == `HCPI_IDX_ACTUAL_TORQUE |=>
        O_OBJ_RDATA[31:15] == 17'h0 || O_OBJ_RDATA[31:15] == 17'h1FFFF)
        else $error("torque outside 16-bit span");
    a_servo_gate: assert property (!I_SERVO_MODE [*2] |=> !O_CSP_ACTIVE)
        else $error("cyclic mode outside servo mode");
    c_homing: cover property (I_HOMING_DONE);
    c_fault: cover property ($rose(O_PERIOD_FAULT));
    c_csp: cover property ($rose(O_CSP_ACTIVE));
endmodule
bind hcpi_top hcpi_checker i_chk (
    .I_MCLK(I_MCLK), .I_RESET(I_RESET), .I_OBJ_WR(I_OBJ_WR), .I_OBJ_RD(I_OBJ_RD),
    .I_OBJ_INDEX(I_OBJ_INDEX), .I_OBJ_SUB(I_OBJ_SUB), .I_OBJ_WDATA(I_OBJ_WDATA),
    .O_OBJ_RDATA(O_OBJ_RDATA), .O_OBJ_ACK(O_OBJ_ACK), .O_OBJ_ERR(O_OBJ_ERR),
    .I_SERVO_MODE(I_SERVO_MODE), .I_HOMING_DONE(I_HOMING_DONE),
    .I_HOME_FOUND_POS(I_HOME_FOUND_POS), .I_FEEDBACK_POS(I_FEEDBACK_POS),
    .O_CSP_ACTIVE(O_CSP_ACTIVE), .O_PERIOD_FAULT(O_PERIOD_FAULT), .O_ZERO_POS(O_ZERO_POS),
    .O_APP_POS(O_APP_POS), .O_HOMING_METHOD(O_HOMING_METHOD),
    .O_HOMING_ACCEL(O_HOMING_ACCEL), .O_HOMING_DECEL(O_HOMING_DECEL));

// [testbench/hcpi_master_model.sv]
`timescale 1ns/1ns
// ==========================================
// motion master: distributed clock sync edges, silent while sync is off
module hcpi_master_model #(
    parameter SYNC_CYCLES = 20
) (
    input  wire i_clk,
    input  wire i_reset,
    input  wire i_dc_enable,
    output reg  o_sync_pulse
);
    localparam [15:0] LAST = SYNC_CYCLES - 1;
    reg [15:0] cnt_q;
    // interval kept equal to one loop cycle, so it is a whole multiple of it
    always @(posedge i_clk) begin
        if (i_reset || !i_dc_enable) begin
            cnt_q        <= 16'h0000;
            o_sync_pulse <= 1'b0;
        end else begin
            o_sync_pulse <= (cnt_q == 16'h0000);
            cnt_q        <= (cnt_q == LAST) ? 16'h0000 : cnt_q + 16'h0001;
        end
    end
endmodule

// [testbench/hcpi_top_tb.sv]
`timescale 1ns/1ns
`include "hcpi_defs.vh"
module hcpi_top_tb;
    localparam LOOP = 20;
    reg         clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, gerr;
    reg         servo = 1'b0, csp = 1'b0, dc = 1'b0, home = 1'b0;
    reg  [15:0] idx = 16'h0000;
    reg  [7:0]  sub = 8'h00;
    reg  [31:0] wd = 32'h00000000, found = 32'h00000000, fb = 32'h00000000;
    reg  [31:0] tq = 32'h00000000, got;
    wire [31:0] rdata, pos, vel, zero, app, sws, zrs, acc, dec;
    wire [7:0]  meth;
    wire        ack, err, active, fault, sync;
    integer     err_total = 0, tests_run = 0, i;
    logic [7:0]  mt [0:2] = '{8'h00, 8'h01, 8'h23};
    logic [31:0] traw [0:3] = '{32'h000186A0, 32'hFFFFFFFB, 32'hFFFE7960, 32'h00007FFF};
    logic [31:0] texp [0:3] = '{32'h00007FFF, 32'hFFFFFFFB, 32'hFFFF8000, 32'h00007FFF};
    always #2 clk = ~clk;
    hcpi_top #(.LOOP_CYCLES(LOOP)) i_dut (
        .I_MCLK(clk), .I_RESET(rst), .I_OBJ_WR(wr), .I_OBJ_RD(rd), .I_OBJ_INDEX(idx),
        .I_OBJ_SUB(sub), .I_OBJ_WDATA(wd), .O_OBJ_RDATA(rdata), .O_OBJ_ACK(ack),
        .O_OBJ_ERR(err), .I_SERVO_MODE(servo), .I_CSP_SELECT(csp), .I_DC_ENABLE(dc),
        .I_SYNC_PULSE(sync), .I_HOMING_DONE(home), .I_HOME_FOUND_POS(found),
        .I_FEEDBACK_POS(fb), .I_TORQUE_RAW(tq), .O_CSP_ACTIVE(active),
        .O_PERIOD_FAULT(fault), .O_POS_CMD(pos), .O_VEL_FF(vel), .O_ZERO_POS(zero),
        .O_APP_POS(app), .O_HOMING_METHOD(meth), .O_SWITCH_SPEED(sws),
        .O_ZERO_SPEED(zrs), .O_HOMING_ACCEL(acc), .O_HOMING_DECEL(dec));
    hcpi_master_model #(.SYNC_CYCLES(LOOP)) i_master (
        .i_clk(clk), .i_reset(rst), .i_dc_enable(dc), .o_sync_pulse(sync));
    // ==========================================
    // compare and access tasks
    task chk(input string nm, input logic [32:0] g, input logic [32:0] e);
        begin
            tests_run = tests_run + 1;
            if (g !== e) begin
                err_total = err_total + 1;
                $display("ERROR %s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    // one request pulse, then wait a bounded time for the acknowledge
    task rw(input logic w, input logic [15:0] ix, input logic [7:0] sb,
            input logic [31:0] d, input logic e, input string nm);
        integer n;
        begin
            @(posedge clk);
            wr  <= w;
            rd  <= ~w;
            idx <= ix;
            sub <= sb;
            wd  <= d;
            @(posedge clk);
            wr <= 1'b0;
            rd <= 1'b0;
            n = 0;
            #1;
            while (ack !== 1'b1 && n < 3) begin
                @(posedge clk);
                #1;
                n = n + 1;
            end
            got  = rdata;
            gerr = err;
            chk(nm, {gerr, w ? 32'h00000000 : got}, {e, w ? 32'h00000000 : d});
        end
    endtask
    task tick(input integer n);
        begin
            repeat (n) @(posedge clk);
            #1;
        end
    endtask
    task results;
        begin
            $display("checks %0d mismatches %0d", tests_run, err_total);
            if (err_total == 0 && tests_run > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    initial begin
        #100000;
        err_total = err_total + 1;
        $display("ERROR watchdog expected finish seen timeout");
        results;
    end
    // ==========================================
    // main sequence
    initial begin
        tick(2);
        rst <= 1'b0;
        rw(0, `HCPI_IDX_HOME_ZERO_OFFSET, 8'h00, 32'h0, 0, "offset rst");
        rw(0, `HCPI_IDX_HOMING_METHOD, 8'h00, 32'h0, 0, "method rst");
        rw(0, `HCPI_IDX_HOMING_SPEEDS, 8'h00, 32'h00000002, 0, "speed count");
        rw(0, `HCPI_IDX_HOMING_SPEEDS, 8'h01, 32'h0, 0, "switch rst");
        rw(0, `HCPI_IDX_HOMING_SPEEDS, 8'h02, 32'h0, 0, "zero rst");
        rw(0, `HCPI_IDX_HOMING_ACCEL, 8'h00, 32'h0, 0, "accel rst");
        rw(0, 16'h6010, 8'h00, 32'h0, 1, "unmapped");
        // negative offset moves zero below the found home
        rw(1, `HCPI_IDX_HOME_ZERO_OFFSET, 8'h00, 32'hFFFFFF38, 0, "offset wr");
        rw(0, `HCPI_IDX_HOME_ZERO_OFFSET, 8'h00, 32'hFFFFFF38, 0, "offset rd");
        found <= 32'h000003E8;
        home  <= 1'b1;
        tick(1);
        home <= 1'b0;
        tick(2);
        chk("zero pos", {1'b0, zero}, {1'b0, 32'h00000320});
        fb <= 32'h000004B0;
        tick(3);
        chk("app pos", {1'b0, app}, {1'b0, 32'h00000190});
        for (i = 0; i < 3; i = i + 1) begin
            rw(1, `HCPI_IDX_HOMING_METHOD, 8'h00, {24'h000000, mt[i]}, 0, "method wr");
            tick(1);
            chk("method out", {25'h0, meth}, {25'h0, mt[i]});
        end
        rw(1, `HCPI_IDX_HOMING_METHOD, 8'h00, 32'h00000024, 1, "method 36");
        rw(0, `HCPI_IDX_HOMING_METHOD, 8'h00, 32'h00000023, 0, "method kept");
        rw(1, `HCPI_IDX_HOMING_SPEEDS, 8'h01, 32'h00001234, 0, "switch wr");
        rw(1, `HCPI_IDX_HOMING_SPEEDS, 8'h02, 32'h00000567, 0, "zero wr");
        rw(1, `HCPI_IDX_HOMING_SPEEDS, 8'h00, 32'h00000003, 1, "count ro");
        chk("speeds", {1'b0, sws[15:0], zrs[15:0]}, {1'b0, 32'h12340567});
        rw(1, `HCPI_IDX_HOMING_ACCEL, 8'h00, 32'h0000ABCD, 0, "accel wr");
        tick(1);
        chk("accel", {dec !== acc, acc}, {1'b0, 32'h0000ABCD});
        for (i = 0; i < 4; i = i + 1) begin
            tq <= traw[i];
            tick(2);
            rw(0, `HCPI_IDX_ACTUAL_TORQUE, 8'h00, texp[i], 0, "torque");
        end
        rw(1, `HCPI_IDX_ACTUAL_TORQUE, 8'h00, 32'h00000000, 1, "torque ro");
        // period checks: 250 us at the finest unit is legal, 300 us is not
        servo <= 1'b1;
        csp   <= 1'b1;
        dc    <= 1'b1;
        rw(1, `HCPI_IDX_INTERP_PERIOD, 8'h02, 32'h000000F9, 0, "exp -7");
        tick(4);
        chk("fault -7", {1'b0, 31'h0, fault}, {1'b0, 32'h00000001});
        rw(1, `HCPI_IDX_INTERP_PERIOD, 8'h01, 32'h000000FA, 0, "units 250");
        rw(1, `HCPI_IDX_INTERP_PERIOD, 8'h02, 32'h000000FA, 0, "exp -6");
        tick(4);
        chk("fault -6", {1'b0, 31'h0, fault}, {1'b0, 32'h00000000});
        rw(1, `HCPI_IDX_INTERP_PERIOD, 8'h01, 32'h00000003, 0, "units 3");
        rw(1, `HCPI_IDX_INTERP_PERIOD, 8'h02, 32'h000000FC, 0, "exp -4");
        tick(4);
        chk("fault 300us", {1'b0, 31'h0, fault}, {1'b0, 32'h00000001});
        rw(1, `HCPI_IDX_INTERP_PERIOD, 8'h01, 32'h00000001, 0, "units 1");
        rw(1, `HCPI_IDX_INTERP_PERIOD, 8'h02, 32'h000000FD, 0, "exp -3");
        rw(1, `HCPI_IDX_VELOCITY_OFFSET, 8'h00, 32'h00000007, 0, "vel off");
        for (i = 0; i < 200 && active !== 1'b1; i = i + 1) tick(1);
        chk("active", {fault, 31'h0, active}, {1'b0, 32'h00000001});
        servo <= 1'b0;
        tick(4);
        chk("servo off", {1'b0, 31'h0, active}, {1'b0, 32'h00000000});
        servo <= 1'b1;
        for (i = 0; i < 200 && active !== 1'b1; i = i + 1) tick(1);
        // 1 ms period is four loop cycles, so 400 steps by 100
        rw(1, `HCPI_IDX_TARGET_POSITION, 8'h00, 32'h00000190, 0, "target");
        for (i = 0; i < 400 && pos === 32'h00000320; i = i + 1) tick(1);
        chk("first step", {1'b0, pos}, {1'b0, 32'h00000384});
        tick(8);
        chk("vel ff", {1'b0, vel}, {1'b0, 32'h0000006B});
        tick(400);
        chk("pos end", {1'b0, pos}, {1'b0, 32'h000004B0});
        chk("vel rest", {1'b0, vel}, {1'b0, 32'h00000007});
        // sync off: the loop divider alone paces the interpolation
        dc <= 1'b0;
        rw(1, `HCPI_IDX_TARGET_POSITION, 8'h00, 32'hFFFFFF38, 0, "target neg");
        tick(500);
        chk("pos free run", {1'b0, pos}, {1'b0, 32'h00000258});
        results;
    end
endmodule
